// ===== design/sbcl_pkg.sv
// Purpose: shared constants and types for the bank command legality pair
// Assumes: one clock at 125 MHz, command pins sampled on rising edges
// Notes: timing figures in ns, cycle counts derived from the clock period
package sbcl_pkg;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int BANK_W = 3;
    localparam int NUM_BANKS = 8;
    localparam int ADDR_W = 14;
    localparam int AP_BIT = 10;
    localparam int CNT_W = 8;
    // timing in ns, as printed defaults
    localparam int PRECHARGE_PERIOD_NS = 15;
    localparam int ROW_TO_COLUMN_DELAY_NS = 15;
    localparam int WRITE_RECOVERY_TIME_NS = 15;
    localparam int ROW_CYCLE_TIME_NS = 60;
    localparam int MODE_SET_DELAY_NS = 16;
    // burst lengths in clocks (two data beats per clock)
    localparam int BL4_CLKS = 2;
    localparam int BL8_CLKS = 4;
    localparam int BURST_BOUNDARY_CLKS = 2;
    // least times round up to whole cycles, never below one
    function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        if (c < 1) begin
            c = 1;
        end
        return c[CNT_W-1:0];
    endfunction
    localparam logic [CNT_W-1:0] PRECHARGE_PERIOD_CYC = ns_to_cyc(PRECHARGE_PERIOD_NS);
    localparam logic [CNT_W-1:0] ROW_TO_COLUMN_DELAY_CYC = ns_to_cyc(ROW_TO_COLUMN_DELAY_NS);
    localparam logic [CNT_W-1:0] WRITE_RECOVERY_TIME_CYC = ns_to_cyc(WRITE_RECOVERY_TIME_NS);
    localparam logic [CNT_W-1:0] ROW_CYCLE_TIME_CYC = ns_to_cyc(ROW_CYCLE_TIME_NS);
    localparam logic [CNT_W-1:0] MODE_SET_DELAY_CYC = ns_to_cyc(MODE_SET_DELAY_NS);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

    // decoded command from cs/ras/cas/we
    typedef enum logic [2:0] {
        CMD_DESELECT, CMD_NOP, CMD_READ, CMD_WRITE,
        CMD_ACTIVATE, CMD_PRECHARGE, CMD_REFRESH, CMD_MODE_SET
    } sbcl_cmd_e;

    typedef enum logic [3:0] {
        BS_IDLE, BS_ACTIVE, BS_READ, BS_WRITE, BS_READ_AP, BS_WRITE_AP,
        BS_PRECHARGING, BS_ACTIVATING, BS_WRITE_REC, BS_WRITE_REC_AP,
        BS_REFRESHING, BS_MODE_ACCESS
    } sbcl_bank_state_e;

    function automatic sbcl_cmd_e decode_cmd(input logic cs_n, input logic ras_n,
                                             input logic cas_n, input logic we_n);
        sbcl_cmd_e c;
        c = CMD_DESELECT;
        if (!cs_n) begin
            unique case ({ras_n, cas_n, we_n})
                3'h7: c = CMD_NOP;
                3'h5: c = CMD_READ;
                3'h4: c = CMD_WRITE;
                3'h3: c = CMD_ACTIVATE;
                3'h2: c = CMD_PRECHARGE;
                3'h1: c = CMD_REFRESH;
                3'h0: c = CMD_MODE_SET;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction

    function automatic logic is_idle_cmd(input sbcl_cmd_e c);
        return (c == CMD_DESELECT) || (c == CMD_NOP);
    endfunction
endpackage

// ===== design/sbcl_cmd_if.sv
// Purpose: command pins between controller and device end
// Assumes: single clock, pins change only around rising edges
// Notes: address also carries the auto precharge bit
`timescale 1ns/1ps
interface sbcl_cmd_if
    import sbcl_pkg::*;
    ();
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, bank, addr);
    modport dev (input cs_n, ras_n, cas_n, we_n, cke, bank, addr);
endinterface

// ===== design/sbcl_device.sv
// Purpose: per-bank state tracking and command legality at the device end
// Assumes: controller keeps its side of the timing; illegal commands flagged
// Notes: illegal commands are reported, flagged bank state unchanged; a precharge-all still closes the other banks in BS_ACTIVE
`timescale 1ns/1ps
module sbcl_device
    import sbcl_pkg::*;
    #(
    parameter int BURST_CLKS = BL8_CLKS
    ) (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    // command pins
    sbcl_cmd_if.dev CMD,
    // status
    output logic ILLEGAL_O,
    output logic SELF_REFRESH_O,
    output logic [NUM_BANKS-1:0] BANK_IDLE_O,
    output logic [NUM_BANKS-1:0] ROW_OPEN_O
);
    sbcl_bank_state_e st_ff [NUM_BANKS];
    sbcl_bank_state_e nxt_st [NUM_BANKS];
    logic [CNT_W-1:0] cnt_ff [NUM_BANKS];
    logic [CNT_W-1:0] nxt_cnt [NUM_BANKS];
    logic illegal_ff, nxt_illegal;
    logic self_ref_ff, nxt_self_ref;
    sbcl_cmd_e cmd;
    logic all_idle;
    logic ap;

    // interrupt lands on a boundary only when the elapsed clocks are a whole step
    function automatic logic off_boundary(input logic [CNT_W-1:0] left);
        logic [CNT_W-1:0] gone;
        gone = CNT_W'(BURST_CLKS) + CNT_ONE - left;
        return (gone % CNT_W'(BURST_BOUNDARY_CLKS)) != CNT_ZERO;
    endfunction

    always_comb begin
        cmd = decode_cmd(CMD.cs_n, CMD.ras_n, CMD.cas_n, CMD.we_n);
        ap = CMD.addr[AP_BIT];
        all_idle = 1'b1;
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (st_ff[b] != BS_IDLE) begin
                all_idle = 1'b0;
            end
        end
    end

    always_comb begin
        logic hit;
        logic bad;
        nxt_illegal = 1'b0;
        nxt_self_ref = self_ref_ff;
        hit = 1'b0;
        bad = 1'b0;
        // self refresh exits when clock enable comes back with deselect/nop
        if (self_ref_ff && CMD.cke && is_idle_cmd(cmd)) begin
            nxt_self_ref = 1'b0;
        end
        for (int b = 0; b < NUM_BANKS; b++) begin
            nxt_st[b] = st_ff[b];
            nxt_cnt[b] = (cnt_ff[b] != CNT_ZERO) ? cnt_ff[b] - CNT_ONE : CNT_ZERO;
            hit = (CMD.bank == b[BANK_W-1:0]);
            bad = 1'b0;
            unique case (st_ff[b])
                BS_IDLE: begin
                    if (hit && cmd == CMD_ACTIVATE) begin
                        nxt_st[b] = BS_ACTIVATING;
                        nxt_cnt[b] = ROW_TO_COLUMN_DELAY_CYC;
                    end else if (hit && (cmd == CMD_READ || cmd == CMD_WRITE)) begin
                        bad = 1'b1;
                    end
                    if (cmd == CMD_PRECHARGE && (hit || ap)) begin
                        nxt_st[b] = BS_PRECHARGING;
                        nxt_cnt[b] = PRECHARGE_PERIOD_CYC;
                    end
                    if (cmd == CMD_REFRESH && all_idle) begin
                        nxt_st[b] = BS_REFRESHING;
                        nxt_cnt[b] = ROW_CYCLE_TIME_CYC;
                        nxt_self_ref = !CMD.cke;
                    end
                    if (cmd == CMD_MODE_SET && all_idle) begin
                        nxt_st[b] = BS_MODE_ACCESS;
                        nxt_cnt[b] = MODE_SET_DELAY_CYC;
                    end
                end
                BS_ACTIVE, BS_READ, BS_WRITE: begin
                    if (cmd == CMD_PRECHARGE && (hit || ap) && st_ff[b] == BS_ACTIVE) begin
                        nxt_st[b] = BS_PRECHARGING;
                        nxt_cnt[b] = PRECHARGE_PERIOD_CYC;
                    end else if (hit && cmd == CMD_READ && st_ff[b] != BS_WRITE) begin
                        // interrupt only on a boundary of a long burst
                        if (st_ff[b] == BS_READ && (BURST_CLKS == BL4_CLKS
                            || off_boundary(cnt_ff[b]))) begin
                            bad = 1'b1;
                        end else begin
                            nxt_st[b] = ap ? BS_READ_AP : BS_READ;
                            nxt_cnt[b] = CNT_W'(BURST_CLKS);
                        end
                    end else if (hit && cmd == CMD_WRITE && st_ff[b] != BS_READ) begin
                        if (st_ff[b] == BS_WRITE && (BURST_CLKS == BL4_CLKS
                            || off_boundary(cnt_ff[b]))) begin
                            bad = 1'b1;
                        end else begin
                            nxt_st[b] = ap ? BS_WRITE_AP : BS_WRITE;
                            nxt_cnt[b] = CNT_W'(BURST_CLKS);
                        end
                    end else if (hit && !is_idle_cmd(cmd)) begin
                        bad = 1'b1;
                    end else if (st_ff[b] != BS_ACTIVE && cnt_ff[b] <= CNT_ONE) begin
                        nxt_st[b] = (st_ff[b] == BS_WRITE) ? BS_WRITE_REC : BS_ACTIVE;
                        nxt_cnt[b] = WRITE_RECOVERY_TIME_CYC;
                    end
                    if ((cmd == CMD_REFRESH || cmd == CMD_MODE_SET)) begin
                        bad = 1'b1;
                    end
                end
                BS_READ_AP, BS_WRITE_AP: begin
                    if (hit && !is_idle_cmd(cmd)) begin
                        bad = 1'b1;
                    end else if (cnt_ff[b] <= CNT_ONE) begin
                        nxt_st[b] = (st_ff[b] == BS_WRITE_AP) ? BS_WRITE_REC_AP
                                                              : BS_PRECHARGING;
                        nxt_cnt[b] = (st_ff[b] == BS_WRITE_AP) ? WRITE_RECOVERY_TIME_CYC
                                                               : PRECHARGE_PERIOD_CYC;
                    end
                end
                BS_PRECHARGING: begin
                    if (hit && !is_idle_cmd(cmd) && cmd != CMD_PRECHARGE) begin
                        bad = 1'b1;
                    end else if (cnt_ff[b] <= CNT_ONE) begin
                        nxt_st[b] = BS_IDLE;
                    end
                end
                BS_ACTIVATING: begin
                    if (hit && !is_idle_cmd(cmd)) begin
                        bad = 1'b1;
                    end else if (cnt_ff[b] <= CNT_ONE) begin
                        nxt_st[b] = BS_ACTIVE;
                    end
                end
                BS_WRITE_REC: begin
                    if (hit && cmd == CMD_WRITE) begin
                        nxt_st[b] = ap ? BS_WRITE_AP : BS_WRITE;
                        nxt_cnt[b] = CNT_W'(BURST_CLKS);
                    end else if (hit && !is_idle_cmd(cmd)) begin
                        bad = 1'b1;
                    end else if (cnt_ff[b] <= CNT_ONE) begin
                        nxt_st[b] = BS_ACTIVE;
                    end
                end
                BS_WRITE_REC_AP: begin
                    if (hit && !is_idle_cmd(cmd)) begin
                        bad = 1'b1;
                    end else if (cnt_ff[b] <= CNT_ONE) begin
                        nxt_st[b] = BS_PRECHARGING;
                        nxt_cnt[b] = PRECHARGE_PERIOD_CYC;
                    end
                end
                BS_REFRESHING: begin
                    // refresh is device-wide, so any command is illegal
                    if (!is_idle_cmd(cmd)) begin
                        bad = 1'b1;
                    end else if (cnt_ff[b] <= CNT_ONE && !self_ref_ff) begin
                        nxt_st[b] = BS_IDLE;
                    end
                end
                BS_MODE_ACCESS: begin
                    if (!is_idle_cmd(cmd)) begin
                        bad = 1'b1;
                    end else if (cnt_ff[b] <= CNT_ONE) begin
                        nxt_st[b] = BS_IDLE;
                    end
                end
            endcase
            if (bad) begin
                // an illegal command leaves the bank as it was
                nxt_st[b] = st_ff[b];
                nxt_cnt[b] = (cnt_ff[b] != CNT_ZERO) ? cnt_ff[b] - CNT_ONE : CNT_ZERO;
                nxt_illegal = 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                st_ff[b] <= BS_IDLE;
                cnt_ff[b] <= CNT_ZERO;
            end
            illegal_ff <= 1'b0;
            self_ref_ff <= 1'b0;
        end else begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                st_ff[b] <= nxt_st[b];
                cnt_ff[b] <= nxt_cnt[b];
            end
            illegal_ff <= nxt_illegal;
            self_ref_ff <= nxt_self_ref;
        end
    end

    always_comb begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            BANK_IDLE_O[b] = (st_ff[b] == BS_IDLE);
            ROW_OPEN_O[b] = (st_ff[b] == BS_ACTIVE) || (st_ff[b] == BS_READ)
                || (st_ff[b] == BS_WRITE) || (st_ff[b] == BS_WRITE_REC);
        end
    end
    assign ILLEGAL_O = illegal_ff;
    assign SELF_REFRESH_O = self_ref_ff;
endmodule

// ===== design/sbcl_ctrl.sv
// Purpose: controller end issuing only legal commands per bank
// Assumes: user holds a request until it is accepted
// Notes: bursts are never interrupted, the simplest legal choice
`timescale 1ns/1ps
module sbcl_ctrl
    import sbcl_pkg::*;
    #(
    parameter int BURST_CLKS = BL8_CLKS
    ) (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    // user request
    input wire logic REQ_VALID_I,
    input wire sbcl_cmd_e REQ_CMD_I,
    input wire logic [BANK_W-1:0] REQ_BANK_I,
    input wire logic [ADDR_W-1:0] REQ_ADDR_I,
    input wire logic REQ_SELF_I,
    output logic REQ_READY_O,
    // command pins
    sbcl_cmd_if.ctrl CMD
);
    logic [CNT_W-1:0] busy_ff [NUM_BANKS];
    logic [CNT_W-1:0] nxt_busy [NUM_BANKS];
    logic [NUM_BANKS-1:0] open_ff, nxt_open;
    logic cs_n_ff, ras_n_ff, cas_n_ff, we_n_ff, cke_ff;
    logic nxt_cs_n, nxt_ras_n, nxt_cas_n, nxt_we_n, nxt_cke;
    logic [BANK_W-1:0] bank_ff, nxt_bank;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic ok;
    logic all_free;
    logic ap;

    // block anything whose target bank or the device is still busy
    always_comb begin
        all_free = 1'b1;
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (busy_ff[b] != CNT_ZERO || open_ff[b]) begin
                all_free = 1'b0;
            end
        end
        ap = REQ_ADDR_I[AP_BIT];
        ok = 1'b0;
        unique case (REQ_CMD_I)
            CMD_DESELECT, CMD_NOP: ok = 1'b1;
            CMD_ACTIVATE: ok = busy_ff[REQ_BANK_I] == CNT_ZERO && !open_ff[REQ_BANK_I];
            CMD_READ, CMD_WRITE: ok = busy_ff[REQ_BANK_I] == CNT_ZERO && open_ff[REQ_BANK_I];
            CMD_PRECHARGE: begin
                ok = busy_ff[REQ_BANK_I] == CNT_ZERO;
                for (int b = 0; b < NUM_BANKS; b++) begin
                    if (ap && busy_ff[b] != CNT_ZERO) begin
                        ok = 1'b0;
                    end
                end
            end
            CMD_REFRESH, CMD_MODE_SET: ok = all_free;
        endcase
        if (!cke_ff) begin
            ok = ok && is_idle_cmd(REQ_CMD_I);
        end
        REQ_READY_O = ok;
    end

    always_comb begin
        logic [CNT_W-1:0] hold;
        hold = CNT_ZERO;
        nxt_open = open_ff;
        nxt_cs_n = 1'b1;
        nxt_ras_n = 1'b1;
        nxt_cas_n = 1'b1;
        nxt_we_n = 1'b1;
        nxt_cke = cke_ff;
        nxt_bank = bank_ff;
        nxt_addr = addr_ff;
        for (int b = 0; b < NUM_BANKS; b++) begin
            // paused in self refresh, the device still needs time after exit
            nxt_busy[b] = (busy_ff[b] != CNT_ZERO && cke_ff) ? busy_ff[b] - CNT_ONE : busy_ff[b];
        end
        // self refresh exit on a deselect or nop request
        if (!cke_ff && REQ_VALID_I && is_idle_cmd(REQ_CMD_I)) begin
            nxt_cke = 1'b1;
        end
        if (REQ_VALID_I && ok && !is_idle_cmd(REQ_CMD_I)) begin
            nxt_cs_n = 1'b0;
            nxt_bank = REQ_BANK_I;
            nxt_addr = REQ_ADDR_I;
            unique case (REQ_CMD_I)
                CMD_READ: {nxt_ras_n, nxt_cas_n, nxt_we_n} = 3'h5;
                CMD_WRITE: {nxt_ras_n, nxt_cas_n, nxt_we_n} = 3'h4;
                CMD_ACTIVATE: {nxt_ras_n, nxt_cas_n, nxt_we_n} = 3'h3;
                CMD_PRECHARGE: {nxt_ras_n, nxt_cas_n, nxt_we_n} = 3'h2;
                CMD_REFRESH: {nxt_ras_n, nxt_cas_n, nxt_we_n} = 3'h1;
                default: {nxt_ras_n, nxt_cas_n, nxt_we_n} = 3'h0;
            endcase
            // extra cycle covers the command edge itself
            unique case (REQ_CMD_I)
                CMD_ACTIVATE: begin
                    nxt_busy[REQ_BANK_I] = ROW_TO_COLUMN_DELAY_CYC + CNT_ONE;
                    nxt_open[REQ_BANK_I] = 1'b1;
                end
                CMD_READ, CMD_WRITE: begin
                    hold = CNT_W'(BURST_CLKS) + CNT_ONE;
                    if (REQ_CMD_I == CMD_WRITE) begin
                        hold = hold + WRITE_RECOVERY_TIME_CYC;
                    end
                    if (ap) begin
                        hold = hold + PRECHARGE_PERIOD_CYC;
                        nxt_open[REQ_BANK_I] = 1'b0;
                    end
                    nxt_busy[REQ_BANK_I] = hold;
                end
                CMD_PRECHARGE: begin
                    for (int b = 0; b < NUM_BANKS; b++) begin
                        if (ap || b[BANK_W-1:0] == REQ_BANK_I) begin
                            nxt_busy[b] = PRECHARGE_PERIOD_CYC + CNT_ONE;
                            nxt_open[b] = 1'b0;
                        end
                    end
                end
                CMD_REFRESH: begin
                    nxt_cke = !REQ_SELF_I;
                    for (int b = 0; b < NUM_BANKS; b++) begin
                        nxt_busy[b] = ROW_CYCLE_TIME_CYC + CNT_ONE;
                    end
                end
                default: begin
                    for (int b = 0; b < NUM_BANKS; b++) begin
                        nxt_busy[b] = MODE_SET_DELAY_CYC + CNT_ONE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                busy_ff[b] <= CNT_ZERO;
            end
            open_ff <= '0;
            cs_n_ff <= 1'b1;
            ras_n_ff <= 1'b1;
            cas_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            cke_ff <= 1'b1;
            bank_ff <= '0;
            addr_ff <= '0;
        end else begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                busy_ff[b] <= nxt_busy[b];
            end
            open_ff <= nxt_open;
            cs_n_ff <= nxt_cs_n;
            ras_n_ff <= nxt_ras_n;
            cas_n_ff <= nxt_cas_n;
            we_n_ff <= nxt_we_n;
            cke_ff <= nxt_cke;
            bank_ff <= nxt_bank;
            addr_ff <= nxt_addr;
        end
    end

    assign CMD.cs_n = cs_n_ff;
    assign CMD.ras_n = ras_n_ff;
    assign CMD.cas_n = cas_n_ff;
    assign CMD.we_n = we_n_ff;
    assign CMD.cke = cke_ff;
    assign CMD.bank = bank_ff;
    assign CMD.addr = addr_ff;
endmodule

// ===== testbench/sbcl_checker.sv
// Purpose: pin level checks between controller and device end
// Assumes: one clock, asynchronous active low reset
// Notes: sees the first interface only, where both ends are design
`timescale 1ns/1ps
module sbcl_checker
    import sbcl_pkg::*;
    (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    // command pins
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic [BANK_W-1:0] bank,
    input wire logic [ADDR_W-1:0] addr,
    // device status
    input wire logic ILLEGAL_O,
    input wire logic SELF_REFRESH_O,
    input wire logic [NUM_BANKS-1:0] BANK_IDLE_O,
    input wire logic [NUM_BANKS-1:0] ROW_OPEN_O
);
    wire sel = !cs_n;
    wire is_cmd = sel && !(ras_n && cas_n && we_n);
    wire is_rw = sel && ras_n && !cas_n;
    wire is_act = sel && !ras_n && cas_n && we_n;
    wire is_pre = sel && !ras_n && cas_n && !we_n;
    wire is_ref = sel && !ras_n && !cas_n && we_n;
    wire is_mrs = sel && !ras_n && !cas_n && !we_n;
    // bank of last command; pins may change while deselected
    logic [BANK_W-1:0] last_bank_ff;
    logic [BANK_W-1:0] nxt_last_bank;
    always_comb begin
        nxt_last_bank = is_cmd ? bank : last_bank_ff;
    end
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            last_bank_ff <= 3'h0;
        end else begin
            last_bank_ff <= nxt_last_bank;
        end
    end
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    sequence s_auto_ref; is_ref && cke; endsequence
    sequence s_quiet; !is_cmd [*7]; endsequence
    property p_no_illegal; !ILLEGAL_O; endproperty
    a_no_illegal: assert property (p_no_illegal) else $error("flag raised");
    property p_act_idle; is_act |-> BANK_IDLE_O[bank]; endproperty
    a_act_idle: assert property (p_act_idle) else $error("open on busy bank");
    property p_act_busy; is_act |-> ##[1:2] !BANK_IDLE_O[last_bank_ff]; endproperty
    a_act_busy: assert property (p_act_busy) else $error("bank not busy");
    property p_rw_open; is_rw |-> ROW_OPEN_O[bank]; endproperty
    a_rw_open: assert property (p_rw_open) else $error("access to closed row");
    property p_quiet_idle; (is_ref || is_mrs) |-> &BANK_IDLE_O; endproperty
    a_quiet_idle: assert property (p_quiet_idle) else $error("bank not idle");
    property p_ref_quiet; s_auto_ref |=> s_quiet; endproperty
    a_ref_quiet: assert property (p_ref_quiet) else $error("command in refresh");
    property p_pre_close; is_pre |-> ##[1:2] !ROW_OPEN_O[last_bank_ff]; endproperty
    a_pre_close: assert property (p_pre_close) else $error("row kept open");
    property p_self_enter; is_ref && !cke |-> ##[1:2] SELF_REFRESH_O; endproperty
    a_self_enter: assert property (p_self_enter) else $error("no self refresh");
    property p_one_cycle; is_cmd |=> !sel; endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("command held");
endmodule

// ===== testbench/test_sbcl_bank_command_legality.sv
// Purpose: self-checking bench for the controller and device pair
// Assumes: 125 MHz clock, reset held 16 cycles
// Notes: a second device takes pins from the bench to see refusals
`timescale 1ns/1ps
module test_sbcl_bank_command_legality;
    import sbcl_pkg::*;
    localparam logic [2:0] P_RD = 3'h5;
    localparam logic [2:0] P_WR = 3'h4;
    localparam logic [2:0] P_ACT = 3'h3;
    localparam logic [2:0] P_PRE = 3'h2;
    localparam logic [2:0] P_REF = 3'h1;
    localparam logic [2:0] P_MRS = 3'h0;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic vld = 1'b0;
    logic rself = 1'b0;
    sbcl_cmd_e rcmd = CMD_NOP;
    logic [BANK_W-1:0] rbank = 3'h0;
    logic [ADDR_W-1:0] raddr = 14'h0000;
    logic rdy, ill, ill2, selfr, pend, pv, acc;
    logic [NUM_BANKS-1:0] idle, open_r;
    logic [31:0] r;
    int miscompares = 0;
    int check_count = 0;
    int seed = 15004;
    int cyc = 0;
    sbcl_cmd_if if_a ();
    sbcl_cmd_if if_b ();
    sbcl_ctrl i_sbcl_ctrl (.SYS_CLK_I(clk), .RST_N_I(rst_n), .REQ_VALID_I(vld),
        .REQ_CMD_I(rcmd), .REQ_BANK_I(rbank), .REQ_ADDR_I(raddr), .REQ_SELF_I(rself),
        .REQ_READY_O(rdy), .CMD(if_a.ctrl));
    sbcl_device i_sbcl_device (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CMD(if_a.dev),
        .ILLEGAL_O(ill), .SELF_REFRESH_O(selfr), .BANK_IDLE_O(idle), .ROW_OPEN_O(open_r));
    sbcl_device i_sbcl_device_b (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CMD(if_b.dev),
        .ILLEGAL_O(ill2), .SELF_REFRESH_O(), .BANK_IDLE_O(), .ROW_OPEN_O());
    sbcl_checker i_sbcl_checker (.SYS_CLK_I(clk), .RST_N_I(rst_n), .cs_n(if_a.cs_n),
        .ras_n(if_a.ras_n), .cas_n(if_a.cas_n), .we_n(if_a.we_n), .cke(if_a.cke),
        .bank(if_a.bank), .addr(if_a.addr), .ILLEGAL_O(ill), .SELF_REFRESH_O(selfr),
        .BANK_IDLE_O(idle), .ROW_OPEN_O(open_r));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %0h got %0h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // clocks from an auto-precharge read to its bank idle, pipeline not counted
    function automatic int ap_read_clks();
        return BL8_CLKS + int'(PRECHARGE_PERIOD_CYC);
    endfunction
    // user request held until the edge that samples ready high
    task automatic issue(input sbcl_cmd_e c, input int b, input logic [ADDR_W-1:0] a,
                         input logic s, input logic must);
        int n;
        n = 0;
        @(posedge clk);
        vld <= 1'b1;
        rcmd <= c;
        rbank <= b[BANK_W-1:0];
        raddr <= a;
        rself <= s;
        @(negedge clk);
        while (rdy !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (must) chk("taken", 1'b1, rdy);
        @(posedge clk);
        vld <= 1'b0;
    endtask
    task automatic try_no(input sbcl_cmd_e c, input int b);
        @(posedge clk);
        vld <= 1'b1;
        rcmd <= c;
        rbank <= b[BANK_W-1:0];
        @(negedge clk);
        chk("refused", 1'b0, rdy);
    endtask
    // flag may land on either of two edges, so both are merged
    task automatic flush();
        chk("flag", pv ? pend : 1'b0, pv ? (acc | ill2) : ill2);
        pv = 1'b0;
    endtask
    task automatic drv(input logic [2:0] p, input int b, input logic ap, input logic e,
                       input int w);
        @(posedge clk);
        {if_b.ras_n, if_b.cas_n, if_b.we_n, if_b.cs_n} <= {p, 1'b0};
        if_b.bank <= b[BANK_W-1:0];
        if_b.addr <= {3'h0, ap, 10'h000};
        @(negedge clk);
        flush();
        @(posedge clk);
        if_b.cs_n <= 1'b1;
        {if_b.ras_n, if_b.cas_n, if_b.we_n, if_b.bank, if_b.addr} <=
            ~{if_b.ras_n, if_b.cas_n, if_b.we_n, if_b.bank, if_b.addr};
        @(negedge clk);
        {acc, pend, pv} = {ill2, e, 1'b1};
        repeat (w) begin
            @(negedge clk);
            flush();
        end
    endtask
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            stop_test();
        end
    end
    always @(negedge clk) begin
        if (rst_n) chk("pair_flag", 1'b0, ill);
    end
    initial begin
        {if_b.cs_n, if_b.ras_n, if_b.cas_n, if_b.we_n, if_b.cke} = 5'h1F;
        {if_b.bank, if_b.addr, pend, pv, acc} = 20'h00000;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        issue(CMD_REFRESH, 0, 14'h0000, 1'b0, 1'b1);
        for (int c = 2; c < 8; c++) try_no(sbcl_cmd_e'(c), 0);
        @(posedge clk);
        vld <= 1'b0;
        issue(CMD_ACTIVATE, 2, 14'h0123, 1'b0, 1'b1);
        try_no(CMD_READ, 2);
        @(posedge clk);
        vld <= 1'b0;
        issue(CMD_ACTIVATE, 3, 14'h0055, 1'b0, 1'b1);
        issue(CMD_READ, 2, 14'h0400, 1'b0, 1'b1);
        try_no(CMD_ACTIVATE, 2);
        @(posedge clk);
        vld <= 1'b0;
        repeat (2 * ap_read_clks()) @(negedge clk);
        chk("ap_idle", 1'b1, idle[2]);
        issue(CMD_PRECHARGE, 0, 14'h0400, 1'b0, 1'b1);
        issue(CMD_REFRESH, 0, 14'h0000, 1'b1, 1'b1);
        repeat (4) @(negedge clk);
        chk("self", 1'b1, selfr);
        chk("cke", 1'b0, if_a.cke);
        issue(CMD_NOP, 0, 14'h0000, 1'b0, 1'b1);
        repeat (8) @(negedge clk);
        chk("self_exit", 1'b0, selfr);
        issue(CMD_MODE_SET, 0, 14'h0042, 1'b0, 1'b1);
        try_no(CMD_ACTIVATE, 1);
        @(posedge clk);
        vld <= 1'b0;
        repeat (300) begin
            r = $random(seed);
            issue(sbcl_cmd_e'(3'h2 + r[2:0] % 3'h6), int'(r[5:3]), r[19:6], 1'b0, 1'b0);
        end
        drv(P_ACT, 0, 1'b0, 1'b0, 0);
        drv(P_RD, 0, 1'b0, 1'b1, 0);
        drv(P_ACT, 1, 1'b0, 1'b0, 2);
        drv(P_RD, 0, 1'b1, 1'b0, 0);
        drv(P_ACT, 0, 1'b0, 1'b1, 0);
        drv(P_PRE, 1, 1'b0, 1'b0, 0);
        drv(P_ACT, 1, 1'b0, 1'b1, 0);
        drv(P_PRE, 1, 1'b0, 1'b0, 12);
        drv(P_REF, 0, 1'b0, 1'b0, 0);
        drv(P_ACT, 2, 1'b0, 1'b1, 12);
        drv(P_MRS, 0, 1'b0, 1'b0, 0);
        drv(P_ACT, 2, 1'b0, 1'b1, 4);
        drv(P_ACT, 3, 1'b0, 1'b0, 2);
        drv(P_WR, 3, 1'b1, 1'b0, 4);
        drv(P_RD, 3, 1'b0, 1'b1, 0);
        drv(P_ACT, 4, 1'b0, 1'b0, 2);
        drv(P_WR, 4, 1'b0, 1'b0, 0);
        drv(P_RD, 4, 1'b0, 1'b1, 1);
        drv(P_WR, 4, 1'b0, 1'b0, 8);
        drv(P_REF, 0, 1'b0, 1'b1, 0);
        drv(P_PRE, 0, 1'b1, 1'b0, 4);
        drv(P_REF, 0, 1'b0, 1'b0, 12);
        drv(P_ACT, 5, 1'b0, 1'b0, 2);
        drv(P_RD, 5, 1'b0, 1'b0, 0);
        drv(P_RD, 5, 1'b0, 1'b0, 1);
        drv(P_RD, 5, 1'b0, 1'b1, 1);
        stop_test();
    end
endmodule
